/* File: common/fsfm_map.svh */
// Purpose: register offsets, field positions and timing figures of the fault manager
// Assumes: 32-bit AHB-Lite words, byte offsets, 100 MHz core clock
// Notes: definitions only
`ifndef FSFM_MAP_SVH
`define FSFM_MAP_SVH

// register byte offsets
`define FSFM_A_CTRL      8'h00
`define FSFM_A_CHAN_EN   8'h04
`define FSFM_A_DIAG_EN   8'h08
`define FSFM_A_CFG       8'h0C
`define FSFM_A_STATUS    8'h10
`define FSFM_A_OPEN      8'h14
`define FSFM_A_SHORT     8'h18
`define FSFM_A_SUPPLY    8'h1C

// control field positions
`define FSFM_CTRL_CLR    0
`define FSFM_CTRL_MREF   1
`define FSFM_CTRL_MOPEN  2
`define FSFM_CTRL_MSHORT 3
`define FSFM_CTRL_MOT    4
`define FSFM_CTRL_MCRC   5

// config field positions
`define FSFM_CFG_TH_LSB  0
`define FSFM_CFG_PW_LSB  8
`define FSFM_CFG_IR_LSB  12

// status field positions
`define FSFM_ST_ERR      0
`define FSFM_ST_OUT      1
`define FSFM_ST_POR      2
`define FSFM_ST_LOWSUP   3
`define FSFM_ST_REF      4
`define FSFM_ST_OT       5
`define FSFM_ST_CRC      6

// reset values
`define FSFM_RST_CFG     18'h00000
`define FSFM_RST_CH      12'h000

// timing
`define FSFM_CLK_MHZ     100
`define FSFM_TICK_NS     1000
`define FSFM_OPEN_DEG_US 10
`define FSFM_SHORT_DEG_US 10
`define FSFM_CONV_US     10
`define FSFM_RETRY_MS    10

`endif

/* File: common/fsfm_pkg.sv */
// Purpose: shared types of the fault manager
// Assumes: nothing
// Notes: one-hot channel recovery states
package fsfm_pkg;
  typedef enum logic [2:0] {
    CH_ON     = 3'b001,
    CH_FAILED = 3'b010,
    CH_RETRY  = 3'b100
  } chan_state_t;
endpackage

/* File: common/diag_cfg_if.sv */
// Purpose: common diagnostic settings fanned out to every channel
// Assumes: driven from the core clock domain
// Notes: tick is a one-cycle pulse per microsecond
`timescale 1ns/1ns
interface diag_cfg_if;
  logic       us_tick;
  logic [3:0] pw_code;
  logic       supply_ok;
  logic       fs_active;
  modport src  (output us_tick, output pw_code, output supply_ok, output fs_active);
  modport sink (input us_tick, input pw_code, input supply_ok, input fs_active);
endinterface

/* File: rtl/sync3.sv */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to hclk
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ns
module sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

/* File: rtl/chan_diag.sv */
// Purpose: per-channel open/short qualification and timed low-current retry
// Assumes: raw fault inputs already synchronised
// Notes: all timing counts in microsecond ticks
`timescale 1ns/1ns
`include "fsfm_map.svh"
module chan_diag #(
  parameter int RETRY_TICKS = `FSFM_RETRY_MS * 1000
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // common settings
  diag_cfg_if.sink  cfg,
  // channel inputs
  input  wire logic chan_en,
  input  wire logic diag_en,
  input  wire logic pwm_on,
  input  wire logic open_raw,
  input  wire logic short_raw,
  // channel results
  output logic      open_evt,
  output logic      short_evt,
  output logic      retry_ok,
  output logic      failed,
  output logic      retry_on
);
  fsfm_pkg::chan_state_t st_q;
  logic [5:0]  dg_q;
  logic [13:0] wait_q;
  logic        det_open;
  logic        det_short;
  logic        is_short_q;
  logic [5:0]  win;
  logic [5:0]  pw_len;
  logic        still_bad;

  assign det_open  = pwm_on & chan_en & diag_en & open_raw & cfg.supply_ok;
  assign det_short = pwm_on & chan_en & diag_en & short_raw;
  assign win       = {2'h0, cfg.pw_code} + (det_short ? 6'(`FSFM_SHORT_DEG_US) : 6'(`FSFM_OPEN_DEG_US));
  assign pw_len    = (cfg.pw_code == 4'h0) ? 6'h01 : {2'h0, cfg.pw_code};
  assign still_bad = is_short_q ? short_raw : (open_raw & cfg.supply_ok);
  assign failed    = (st_q != fsfm_pkg::CH_ON);
  assign retry_on  = (st_q == fsfm_pkg::CH_RETRY);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q       <= fsfm_pkg::CH_ON;
      dg_q       <= 6'h00;
      wait_q     <= 14'h0000;
      is_short_q <= 1'b0;
      open_evt   <= 1'b0;
      short_evt  <= 1'b0;
      retry_ok   <= 1'b0;
    end else begin
      open_evt  <= 1'b0;
      short_evt <= 1'b0;
      retry_ok  <= 1'b0;
      case (st_q)
        fsfm_pkg::CH_ON: begin
          if (!(det_open | det_short)) begin
            dg_q <= 6'h00;
          end else if (cfg.us_tick) begin
            if (dg_q > win) begin
              st_q       <= fsfm_pkg::CH_FAILED;
              is_short_q <= det_short;
              open_evt   <= ~det_short;
              short_evt  <= det_short;
              wait_q     <= 14'h0000;
              dg_q       <= 6'h00;
            end else begin
              dg_q <= dg_q + 6'h01;
            end
          end
        end
        fsfm_pkg::CH_FAILED: begin
          if (!diag_en || !chan_en) begin
            st_q <= fsfm_pkg::CH_ON;
          end else if (cfg.fs_active && cfg.us_tick) begin
            if (wait_q == 14'(RETRY_TICKS - 1)) begin
              st_q   <= fsfm_pkg::CH_RETRY;
              wait_q <= 14'h0000;
              dg_q   <= 6'h00;
            end else begin
              wait_q <= wait_q + 14'h0001;
            end
          end
        end
        fsfm_pkg::CH_RETRY: begin
          if (cfg.us_tick) begin
            if (dg_q + 6'h01 >= pw_len) begin
              dg_q <= 6'h00;
              if (still_bad) begin
                st_q <= fsfm_pkg::CH_FAILED;
              end else begin
                st_q     <= fsfm_pkg::CH_ON;
                retry_ok <= 1'b1;
              end
            end else begin
              dg_q <= dg_q + 6'h01;
            end
          end
        end
        default: begin
          st_q <= fsfm_pkg::CH_ON;
        end
      endcase
    end
  end

  a_retry_ends_ok: assert property (@(posedge hclk) disable iff (!hresetn)
    retry_ok |-> !failed) else $error("retry success left channel failed");
endmodule

/* File: rtl/failsafe_fault_manager.sv */
// Purpose: fail-safe fault gathering, masking, flags, error pin and channel shut-off
// Assumes: AHB-Lite single word transfers; fault pins asynchronous; pwm/adc/crc on hclk
// Notes: error pin is open-drain, pulled low while err_oe_n is low
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "fsfm_map.svh"
// Functional notes
// - all fault detectors keep running and report through error pin and flags; low supply reports through flags only, never the pin
// - all-fail option set: any LED fault turns off every output, else only that channel
// - fault flags stay readable over the register bus
// - masks never stop detection, only the summary flags and the error pin
// - diagnostics disabled on a channel: its faults are ignored entirely
// - reference, overtemperature and CRC masks block error summary and pin
// - open and short masks block output summary, error summary and pin
// - supply undervoltage enters power-on reset; recovery sets power-on and error flags
// - supply below low threshold sets low-supply and error flags
// - writing one to clear-fault resets latched flags; the bit returns to zero
// - converter samples supply every 10 us when idle; result register refreshed
// - reference fault pulls error pin low, sets reference and error flags
// - reference fault turns all outputs off; recovery automatic, flag needs clear
// - overtemperature turns outputs off, pulls pin low, sets flags
// - overtemperature gone: outputs and pin restored, flag held until clear
// - open check only during PWM on-time longer than pulse width plus deglitch
// - qualified open above low supply: channel off, pin low, open/out/error flags
// - open check skips channels whose enable is zero
// - open-failed channel retried every 10 ms; success releases pin and flags
// - qualified short: channel off, pin low, short/out/error flags
// - short-failed channel retried every 10 ms; success restores current and flags
module failsafe_fault_manager #(
  parameter int RETRY_TICKS = `FSFM_RETRY_MS * 1000
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // asynchronous fault indications
  input  wire logic        supply_uv,
  input  wire logic        ref_fault,
  input  wire logic        overtemp,
  input  wire logic [11:0] chan_open,
  input  wire logic [11:0] chan_short,
  // core-clock inputs
  input  wire logic        fs_active,
  input  wire logic        all_fail_option,
  input  wire logic        crc_fault,
  input  wire logic [11:0] pwm_on,
  input  wire logic        adc_idle,
  input  wire logic        adc_valid,
  input  wire logic [7:0]  adc_data,
  // outputs
  output logic             adc_start,
  output logic      [11:0] chan_out_en,
  output logic      [11:0] chan_retry,
  output logic      [5:0]  retry_current,
  output logic             in_por,
  output logic             err_o,
  output logic             err_oe_n
);
  localparam int TICK_CYC = `FSFM_TICK_NS * `FSFM_CLK_MHZ / 1000;
  localparam int CONV_TICKS = `FSFM_CONV_US;

  diag_cfg_if cfg_if ();

  // synchronised pins
  logic [26:0] pins_s;
  logic        uv_s;
  logic        supply_good_s;
  logic        ref_s;
  logic        ot_s;
  logic [11:0] open_s;
  logic [11:0] short_s;

  sync3 #(.W(27)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({~supply_uv, ref_fault, overtemp, chan_open, chan_short}),
    .dout    (pins_s)
  );
  // supply synced as good-level so a cleared synchroniser reads as undervoltage
  assign {supply_good_s, ref_s, ot_s, open_s, short_s} = pins_s;
  assign uv_s = ~supply_good_s;

  // software registers
  logic        fault_clear_q;
  logic [4:0]  mask_q;
  logic [11:0] chan_enable;
  logic [11:0] chan_diag_enable;
  logic [7:0]  low_supply_threshold;
  logic [3:0]  diag_pulse_width;
  logic [5:0]  retry_current_setting;
  logic [7:0]  supply_q;

  // flags
  logic        err_flag_q;
  logic        out_flag_q;
  logic        power_on_flag_q;
  logic        low_supply_flag;
  logic        ref_flag_q;
  logic        overtemp_flag;
  logic        crc_flag_q;
  logic [11:0] chan_open_flag;
  logic [11:0] chan_short_flag;

  // bus state
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        acc;

  // internal
  logic        por_q;
  logic [6:0]  tick_cnt_q;
  logic        us_tick;
  logic [3:0]  conv_cnt_q;
  logic [11:0] open_evt;
  logic [11:0] short_evt;
  logic [11:0] retry_ok;
  logic [11:0] failed;
  logic [11:0] retry_on;
  logic [11:0] qual;
  logic        low_evt;
  logic        err_evt;
  logic        all_off;
  logic        err_drive;
  logic        m_ref;
  logic        m_open;
  logic        m_short;
  logic        m_ot;
  logic        m_crc;

  assign m_ref   = mask_q[`FSFM_CTRL_MREF - 1];
  assign m_open  = mask_q[`FSFM_CTRL_MOPEN - 1];
  assign m_short = mask_q[`FSFM_CTRL_MSHORT - 1];
  assign m_ot    = mask_q[`FSFM_CTRL_MOT - 1];
  assign m_crc   = mask_q[`FSFM_CTRL_MCRC - 1];

  // microsecond tick
  assign us_tick = (tick_cnt_q == 7'(TICK_CYC - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 7'h00;
    end else begin
      tick_cnt_q <= us_tick ? 7'h00 : tick_cnt_q + 7'h01;
    end
  end

  assign cfg_if.us_tick   = us_tick;
  assign cfg_if.pw_code   = diag_pulse_width;
  assign cfg_if.supply_ok = supply_q >= low_supply_threshold;
  assign cfg_if.fs_active = fs_active;

  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_ch
      chan_diag #(.RETRY_TICKS(RETRY_TICKS)) u_ch (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .cfg       (cfg_if.sink),
        .chan_en   (chan_enable[g]),
        .diag_en   (chan_diag_enable[g]),
        .pwm_on    (pwm_on[g]),
        .open_raw  (open_s[g]),
        .short_raw (short_s[g]),
        .open_evt  (open_evt[g]),
        .short_evt (short_evt[g]),
        .retry_ok  (retry_ok[g]),
        .failed    (failed[g]),
        .retry_on  (retry_on[g])
      );
    end
  endgenerate

  // bus slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc & hwrite;
      if (acc) begin
        wr_addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (acc && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        `FSFM_A_CTRL:    hrdata <= {26'h0, mask_q, fault_clear_q};
        `FSFM_A_CHAN_EN: hrdata <= {20'h0, chan_enable};
        `FSFM_A_DIAG_EN: hrdata <= {20'h0, chan_diag_enable};
        `FSFM_A_CFG:     hrdata <= {14'h0, retry_current_setting, diag_pulse_width, low_supply_threshold};
        `FSFM_A_STATUS:  hrdata <= {25'h0, crc_flag_q, overtemp_flag, ref_flag_q, low_supply_flag,
                                    power_on_flag_q, out_flag_q, err_flag_q};
        `FSFM_A_OPEN:    hrdata <= {20'h0, chan_open_flag};
        `FSFM_A_SHORT:   hrdata <= {20'h0, chan_short_flag};
        `FSFM_A_SUPPLY:  hrdata <= {24'h0, supply_q};
        default:         hrdata <= 32'h00000000;
      endcase
    end
  end

  // register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_clear_q         <= 1'b0;
      mask_q                <= 5'h00;
      chan_enable           <= `FSFM_RST_CH;
      chan_diag_enable      <= `FSFM_RST_CH;
      {retry_current_setting, diag_pulse_width, low_supply_threshold} <= `FSFM_RST_CFG;
    end else begin
      fault_clear_q <= 1'b0;
      if (wr_pend_q) begin
        case (wr_addr_q)
          `FSFM_A_CTRL: begin
            fault_clear_q <= hwdata[`FSFM_CTRL_CLR];
            mask_q        <= hwdata[`FSFM_CTRL_MCRC:`FSFM_CTRL_MREF];
          end
          `FSFM_A_CHAN_EN: chan_enable      <= hwdata[11:0];
          `FSFM_A_DIAG_EN: chan_diag_enable <= hwdata[11:0];
          `FSFM_A_CFG: begin
            low_supply_threshold  <= hwdata[`FSFM_CFG_TH_LSB +: 8];
            diag_pulse_width      <= hwdata[`FSFM_CFG_PW_LSB +: 4];
            retry_current_setting <= hwdata[`FSFM_CFG_IR_LSB +: 6];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // supply converter pacing and result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_cnt_q <= 4'h0;
      adc_start  <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      if (us_tick) begin
        if (conv_cnt_q == 4'(CONV_TICKS - 1)) begin
          conv_cnt_q <= 4'h0;
          adc_start  <= adc_idle;
        end else begin
          conv_cnt_q <= conv_cnt_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supply_q <= 8'h00;
    end else if (adc_valid) begin
      supply_q <= adc_data;
    end
  end

  // power-on reset tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_q <= 1'b1;
    end else begin
      por_q <= uv_s;
    end
  end
  assign in_por = por_q;

  // qualified channel faults after diag enable and masks
  assign qual    = chan_diag_enable & ((chan_open_flag & {12{~m_open}}) |
                                       (chan_short_flag & {12{~m_short}}));
  assign low_evt = adc_valid & (adc_data < low_supply_threshold);
  assign err_evt = low_evt | (ref_s & ~m_ref) | (ot_s & ~m_ot) | (crc_fault & ~m_crc) |
                   |(chan_diag_enable & ((open_evt & {12{~m_open}}) | (short_evt & {12{~m_short}})));

  // latched flags: set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_supply_flag <= 1'b0;
      ref_flag_q      <= 1'b0;
      overtemp_flag   <= 1'b0;
      crc_flag_q      <= 1'b0;
    end else if (por_q) begin
      low_supply_flag <= 1'b0;
      ref_flag_q      <= 1'b0;
      overtemp_flag   <= 1'b0;
      crc_flag_q      <= 1'b0;
    end else begin
      low_supply_flag <= low_evt | (low_supply_flag & ~fault_clear_q);
      ref_flag_q      <= ref_s | (ref_flag_q & ~fault_clear_q);
      overtemp_flag   <= ot_s | (overtemp_flag & ~fault_clear_q);
      crc_flag_q      <= crc_fault | (crc_flag_q & ~fault_clear_q);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_open_flag  <= 12'h000;
      chan_short_flag <= 12'h000;
    end else if (por_q) begin
      chan_open_flag  <= 12'h000;
      chan_short_flag <= 12'h000;
    end else begin
      chan_open_flag  <= open_evt |
                         (chan_open_flag & ~retry_ok & {12{~fault_clear_q}});
      chan_short_flag <= short_evt |
                         (chan_short_flag & ~retry_ok & {12{~fault_clear_q}});
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_on_flag_q <= 1'b0;
      err_flag_q      <= 1'b0;
    end else if (por_q) begin
      power_on_flag_q <= ~uv_s;
      err_flag_q      <= ~uv_s;
    end else begin
      power_on_flag_q <= power_on_flag_q & ~fault_clear_q;
      err_flag_q      <= err_evt | (err_flag_q & ~fault_clear_q);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_flag_q <= 1'b0;
    end else begin
      out_flag_q <= |qual;
    end
  end

  // channel drive and error pin
  assign all_off   = por_q | ref_s | ot_s | crc_fault | (all_fail_option & |failed);
  assign err_drive = por_q | (ref_s & ~m_ref) | (ot_s & ~m_ot) | (crc_fault & ~m_crc) | |qual;
  assign err_o     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_out_en   <= 12'h000;
      chan_retry    <= 12'h000;
      retry_current <= 6'h00;
      err_oe_n      <= 1'b1;
    end else begin
      chan_out_en   <= all_off ? 12'h000 : (chan_enable & ~failed);
      chan_retry    <= retry_on;
      retry_current <= retry_current_setting;
      err_oe_n      <= ~err_drive;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_clear_self_return: assert property (fault_clear_q |=> !fault_clear_q)
    else $error("clear bit did not return to zero");
  a_supply_refresh: assert property (adc_valid |=> supply_q == $past(adc_data))
    else $error("supply result not refreshed");
  a_low_supply_set: assert property (low_evt && !por_q |=> low_supply_flag && err_flag_q)
    else $error("low supply flags not set");
  a_ref_pin_low: assert property (ref_s && !m_ref && !por_q |=> !err_oe_n && chan_out_en == 12'h000)
    else $error("reference fault not reported");
  a_ot_outputs_off: assert property (ot_s && !por_q |=> chan_out_en == 12'h000 ##0 overtemp_flag)
    else $error("overtemperature did not shut outputs");
  a_ot_flag_held: assert property (overtemp_flag && !fault_clear_q && !por_q |=> overtemp_flag)
    else $error("overtemperature flag dropped without clear");
  a_all_fail_off: assert property (all_fail_option && |failed |=> chan_out_en == 12'h000)
    else $error("all-fail did not shut outputs");
  a_por_release: assert property (por_q && !uv_s |=> power_on_flag_q && err_flag_q)
    else $error("power-on flags not set at recovery");
  a_mask_quiet_out: assert property (m_short && !(|chan_open_flag) |=> !out_flag_q)
    else $error("output summary set by masked fault");

  c_open_event: cover property (|open_evt);
  c_retry_ok: cover property (|retry_ok);
  c_ot_recover: cover property (ot_s ##1 !ot_s);
  c_clear: cover property (fault_clear_q && err_flag_q);
endmodule

/* File: dv/ahb_host.sv */
// Purpose: AHB-Lite master acting as the controller
// Assumes: single whole-word transfers
// Notes: a hung bus ends the run
`timescale 1ns/1ns
module ahb_host (
  // answer
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // request
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [31:0] hwdata
);
  initial {hsel, haddr, htrans, hwrite, hwdata} = 68'h0;
  // next edge with hready high, bounded
  task automatic rdy();
    for (int n = 0; n < 99; n++) begin
      @(posedge hclk);
      if (hready === 1'h1) return;
    end
    testbench.mismatches++;
    testbench.results();
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
endmodule

/* File: dv/testbench.sv */
// Purpose: self-checking bench for the fail-safe fault manager
// Assumes: retry period cut to 20 us
// Notes: converter answers each start with one code
`timescale 1ns/1ns
module testbench;
  logic        hclk = 1'h0, hresetn = 1'h0, supply_uv = 1'h1, fs_active = 1'h1, adc_idle = 1'h1;
  logic        all_fail_option = 1'h0, adc_valid = 1'h0, hsel, hwrite, hreadyout, hresp, adc_start, in_por;
  logic        err_o, err_oe_n;
  logic [1:0]  htrans;
  logic [2:0]  hsize = 3'h2, cz = 3'h0;
  logic [5:0]  retry_current;
  logic [7:0]  adc_data = 8'h40;
  logic [11:0] pwm_on = 12'hFFF, chan_open = 12'h0, chan_short = 12'h0, chan_out_en, chan_retry;
  logic [31:0] haddr, hwdata, hrdata;
  wire         ref_fault = cz[0], overtemp = cz[1], crc_fault = cz[2], hready = hreadyout;
  int          mismatches = 0, comparisons = 0;
  failsafe_fault_manager #(.RETRY_TICKS(20)) failsafe_fault_manager_i (.*);
  ahb_host ahb_host_i (.*);
  initial forever #5 hclk = ~hclk;
  always @(posedge hclk) adc_valid <= adc_start;
  task automatic step(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
    if (got !== exp) mismatches++;
  endtask
  task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb_host_i.xfer(w, a, d, q);
    if (!w) chk(q, d);
  endtask
  task automatic wait_out(input logic [11:0] e);
    for (int n = 0; n < 5000 && chan_out_en !== e; n++) step(1);
    chk(chan_out_en, e);
    if (chan_out_en !== e) results();
  endtask
  task automatic cause(input int i, input logic m);
    io(1'h1, 8'h00, 32'(m) << (i == 0 ? 1 : i + 3) | 1);
    cz[i] <= 1'h1;
    step(10);
    chk({chan_out_en, err_oe_n}, {12'h000, m});
    io(1'h0, 8'h10, 32'h10 << i | 32'(!m));
    cz[i] <= 1'h0;
    step(10);
    chk({chan_out_en, err_oe_n}, 13'h1FFF);
    io(1'h0, 8'h10, 32'h10 << i | 32'(!m));
  endtask
  // open on channel 0 or short on channel 1, then recovery by retry
  task automatic led(input int k, input logic m, input logic [11:0] e);
    io(1'h1, 8'h00, 32'(m) << (2 + k) | 1);
    chan_open <= 12'(1 - k);
    chan_short <= 12'(2 * k);
    wait_out(e);
    step(2);
    chk(err_oe_n, m);
    io(1'h0, 8'(20 + 4 * k), 32'(k + 1));
    io(1'h0, 8'h10, m ? 32'h0 : 32'h3);
    for (int n = 0; n < 3000 && chan_retry == 12'h000; n++) step(1);
    chk({chan_retry, retry_current}, {12'(1 << k), 6'h05});
    {chan_open, chan_short} <= 24'h0;
    wait_out(12'hFFF);
    step(2);
    chk(err_oe_n, 1'h1);
    io(1'h0, 8'(20 + 4 * k), 32'h0);
  endtask
  task automatic results();
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    step(5);
    chk(in_por, 1'h1);
    {hresetn, supply_uv} <= 2'h2;
    step(10);
    chk(in_por, 1'h0);
    io(1'h0, 8'h10, 32'h5);
    io(1'h1, 8'h00, 32'h1);
    step(1);
    io(1'h0, 8'h00, 32'h0);
    io(1'h0, 8'h10, 32'h0);
    io(1'h1, 8'h04, 32'hFFF);
    io(1'h1, 8'h08, 32'hFFF);
    io(1'h1, 8'h0C, 32'h5000);
    for (int i = 0; i < 6; i++) cause(i / 2, 1'(i % 2));
    led(0, 1'h0, 12'hFFE);
    led(1, 1'h1, 12'hFFD);
    all_fail_option <= 1'h1;
    led(0, 1'h0, 12'h000);
    led(1, 1'h0, 12'h000);
    io(1'h1, 8'h08, 32'hFFE);
    chan_open <= 12'h001;
    step(2000);
    chk({err_oe_n, chan_out_en}, 13'h1FFF);
    io(1'h1, 8'h0C, 32'h80);
    step(1200);
    io(1'h0, 8'h1C, 32'h40);
    io(1'h0, 8'h10, 32'h9);
    io(1'h1, 8'h08, 32'hFFF);
    step(2000);
    chk({err_oe_n, chan_out_en}, 13'h1FFF);
    {supply_uv, adc_data} <= 9'h190;
    step(10);
    chk({in_por, err_oe_n, chan_out_en}, 14'h2000);
    supply_uv <= 1'h0;
    step(10);
    io(1'h0, 8'h10, 32'h5);
    results();
  end
endmodule
